// [rtl/conv_ctrl_pkg.sv]
package conv_ctrl_pkg;
  // Calibration command detector thresholds, in input clock cycles.
  localparam int unsigned CMD_LOW_CYCLES  = 640;
  localparam int unsigned CMD_HIGH_CYCLES = 640;
  // Power-up delay exponents for the two delay-select levels.
  localparam int unsigned DELAY_EXP_SHORT = 25;
  localparam int unsigned DELAY_EXP_LONG  = 31;
  // Pipeline latency of primary and delayed buses, in sample clocks.
  localparam int unsigned LAT_PRIMARY     = 13;
  localparam int unsigned LAT_DELAYED     = 14;
  // Default calibration run length in sample clocks.
  localparam int unsigned CAL_RUN_CYCLES  = 1024;
  localparam logic [7:0]  CODE_ZERO       = 8'h00;
  localparam logic [7:0]  CODE_FULL       = 8'hFF;
  localparam logic [7:0]  CODE_MID        = 8'h80;
  localparam int unsigned CNT_W           = 32;
  localparam int unsigned CMD_CNT_W       = 10;

  // Offset binary: two's complement sample with the sign bit inverted.
  function automatic logic [7:0] toOffsetBin(input logic [7:0] s);
    toOffsetBin = {~s[7], s[6:0]};
  endfunction : toOffsetBin
endpackage : conv_ctrl_pkg

// [rtl/conv_link_if.sv]
`timescale 1ns/100ps
interface conv_link_if;
  import conv_ctrl_pkg::*;
  logic       calReqPin;
  logic       calDelaySelect;
  logic       powerDownPin;
  logic       secondChannelPowerDown;
  logic       rangeSelectPin;
  logic       outputLevelSelect;
  logic       outputEdgeSelect;
  logic       extendedControlEnable;
  logic       dualEdgeEnable;
  logic       calActiveFlag;
  logic       forwardedDataClock;
  logic       outOfRange;
  logic [7:0] iPrimaryBus;
  logic [7:0] iDelayedBus;
  logic [7:0] qPrimaryBus;
  logic [7:0] qDelayedBus;

  modport device (
    input  calReqPin, calDelaySelect, powerDownPin, secondChannelPowerDown,
    input  rangeSelectPin, outputLevelSelect, outputEdgeSelect,
    input  extendedControlEnable, dualEdgeEnable,
    output calActiveFlag, forwardedDataClock, outOfRange,
    output iPrimaryBus, iDelayedBus, qPrimaryBus, qDelayedBus
  );
  modport host (
    output calReqPin, calDelaySelect, powerDownPin, secondChannelPowerDown,
    output rangeSelectPin, outputLevelSelect, outputEdgeSelect,
    output extendedControlEnable, dualEdgeEnable,
    input  calActiveFlag, forwardedDataClock, outOfRange,
    input  iPrimaryBus, iDelayedBus, qPrimaryBus, qDelayedBus
  );
endinterface : conv_link_if

// [rtl/cal_cmd_detect.sv]
`timescale 1ns/100ps
module cal_cmd_detect
  import conv_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic srst,
  // Synchronised request level and one-cycle command pulse.
  input  wire logic reqLevel,
  output logic      cmdPulse
);
  typedef enum logic [1:0] {WAIT_LOW, COUNT_LOW, COUNT_HIGH} detState_t;
  detState_t            state_q;
  logic [CMD_CNT_W-1:0] count_q;

  // An interrupted low phase returns to hunting for a low; an interrupted high phase restarts the low count.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q  <= WAIT_LOW;
      count_q  <= '0;
      cmdPulse <= 1'b0;
    end else begin
      cmdPulse <= 1'b0;
      unique case (state_q)
        WAIT_LOW: begin
          count_q <= CMD_CNT_W'(1);
          if (!reqLevel) state_q <= COUNT_LOW;
        end
        COUNT_LOW: begin
          if (reqLevel) begin
            if (count_q >= CMD_CNT_W'(CMD_LOW_CYCLES)) begin
              state_q <= COUNT_HIGH;
              count_q <= CMD_CNT_W'(1);
            end else begin
              state_q <= WAIT_LOW;
            end
          end else if (count_q < CMD_CNT_W'(CMD_LOW_CYCLES)) begin
            count_q <= count_q + CMD_CNT_W'(1);
          end
        end
        COUNT_HIGH: begin
          if (!reqLevel) begin
            state_q <= COUNT_LOW;
            count_q <= CMD_CNT_W'(1);
          end else if (count_q == CMD_CNT_W'(CMD_HIGH_CYCLES - 1)) begin
            cmdPulse <= 1'b1;
            state_q  <= WAIT_LOW;
          end else begin
            count_q <= count_q + CMD_CNT_W'(1);
          end
        end
        default: state_q <= WAIT_LOW;
      endcase
    end
  end
endmodule : cal_cmd_detect

// [rtl/conv_device.sv]
`timescale 1ns/100ps
// Behaviour
// - Below negative full scale outputs all zeros.
// - Above positive full scale outputs all ones.
// - One out-of-range flag for either channel.
// - Each converter alternates samples onto two buses.
// - Calibration flag high throughout every calibration.
// - Command is 640 low then 640 high.
// - Request high at power-up suppresses power-up calibration.
// - Power-up delay 2^25 or 2^31 by select.
// - Power-down at power-up holds delay counter.
// - No calibration start or run while powered down.
// - Host recalibrates after every range-select pin change.
// - Host recalibrates later and on temperature change.
// - Results after 13 and 14 clocks.
// - Output words are offset binary.
// - Extended mode takes settings from registers.
// - Control mode fixed while operating.
// - Dual-edge mode: converters share one input.
// - Dual-edge order: Qd, Id, Q, I.
// - Q input selectable only in extended mode.
// - Host waits for a calibration before raising the dual-edge pin.
// - Power-down deferred during calibration; requests ignored.
// - Dual-edge Q buses lag 13 and 14, as the I buses do.
module conv_device
  import conv_ctrl_pkg::*;
#(
  parameter int unsigned CAL_RUN  = CAL_RUN_CYCLES,
  parameter int unsigned EXP_LOW  = DELAY_EXP_SHORT,
  parameter int unsigned EXP_HIGH = DELAY_EXP_LONG
) (
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic srst,
  // Link to the host.
  conv_link_if.device link,
  // Converter sample inputs, two's complement, with clip indicators.
  input  wire logic [7:0] iSample,
  input  wire logic       iBelow,
  input  wire logic       iAbove,
  input  wire logic [7:0] qSample,
  input  wire logic       qBelow,
  input  wire logic       qAbove,
  // Extended-control settings held in the register file.
  input  wire logic       regOutputLevel,
  input  wire logic       regOutputEdge,
  input  wire logic       regRangeSelect,
  input  wire logic       regDualEdge,
  input  wire logic       regQSelect,
  // Effective settings and power state.
  output logic            effOutputLevel,
  output logic            effOutputEdge,
  output logic            effRangeSelect,
  output logic            powerDownActive
);
  typedef enum logic [1:0] {PWRUP_WAIT, IDLE, CALIBRATING} calState_t;

  logic [1:0]       calReqSync_q;
  logic [1:0]       pdSync_q;
  logic [1:0]       dlySync_q;
  logic             cmdPulse;
  logic             pwrupCalDone_q;
  logic             holdOff_q;
  calState_t        calState_q;
  logic [CNT_W-1:0] delayCnt_q;
  logic [CNT_W-1:0] runCnt_q;
  logic             dualEdge;
  logic [7:0]       iCode;
  logic [7:0]       qCode;
  logic             clip;
  logic [7:0]       iPipe_q [LAT_PRIMARY];
  logic [7:0]       qPipe_q [LAT_PRIMARY];
  logic [LAT_PRIMARY-1:0] orPipe_q;
  logic             phase_q;
  logic [7:0]       iHold_q;
  logic [7:0]       qHold_q;

  // Request, power-down and delay-select pins arrive from the board and are synchronised first.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      // The request pin idles high, so the synchroniser starts there too.
      // A low reset value would look like a request at power-up.
      calReqSync_q <= 2'h3;
      pdSync_q     <= '0;
      dlySync_q    <= '0;
    end else begin
      calReqSync_q <= {calReqSync_q[0], link.calReqPin};
      pdSync_q     <= {pdSync_q[0], link.powerDownPin};
      dlySync_q    <= {dlySync_q[0], link.calDelaySelect};
    end
  end

  cal_cmd_detect u_cmd (
    .core_clk (core_clk),
    .srst     (srst),
    .reqLevel (calReqSync_q[1]),
    .cmdPulse (cmdPulse)
  );

  // The request level is caught one cycle after reset release.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      holdOff_q <= 1'b0;
      pwrupCalDone_q <= 1'b0;
    end else if (calState_q == PWRUP_WAIT && delayCnt_q == '0 &&
                 !pwrupCalDone_q) begin
      holdOff_q <= calReqSync_q[1];
      pwrupCalDone_q <= 1'b1;
    end else if (cmdPulse) begin
      holdOff_q <= 1'b0;
    end
  end

  // Calibration sequencer; power-down only takes effect outside a run.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      calState_q      <= PWRUP_WAIT;
      delayCnt_q      <= '0;
      runCnt_q        <= '0;
      powerDownActive <= 1'b0;
    end else begin
      if (calState_q != CALIBRATING) begin
        powerDownActive <= pdSync_q[1];
      end
      unique case (calState_q)
        PWRUP_WAIT: begin
          if (!pdSync_q[1]) begin
            delayCnt_q <= delayCnt_q + CNT_W'(1);
            if (delayCnt_q == (dlySync_q[1] ? CNT_W'((64'd1 << EXP_HIGH) - 1)
                               : CNT_W'((64'd1 << EXP_LOW) - 1))) begin
              calState_q <= holdOff_q ? IDLE : CALIBRATING;
              runCnt_q   <= '0;
            end
          end
        end
        IDLE: begin
          if (cmdPulse && !pdSync_q[1] && !powerDownActive) begin
            calState_q <= CALIBRATING;
            runCnt_q   <= '0;
          end
        end
        CALIBRATING: begin
          runCnt_q <= runCnt_q + CNT_W'(1);
          if (runCnt_q == CNT_W'(CAL_RUN - 1)) calState_q <= IDLE;
        end
        default: calState_q <= IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) link.calActiveFlag <= 1'b0;
    else link.calActiveFlag <= (calState_q == CALIBRATING);
  end

  // Extended mode takes its settings from registers, not pins.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      effOutputLevel <= 1'b0;
      effOutputEdge  <= 1'b0;
      effRangeSelect <= 1'b0;
    end else begin
      effOutputLevel <= link.extendedControlEnable ? regOutputLevel
                                                   : link.outputLevelSelect;
      effOutputEdge  <= link.extendedControlEnable ? regOutputEdge
                                                   : link.outputEdgeSelect;
      effRangeSelect <= link.extendedControlEnable ? regRangeSelect
                                                   : link.rangeSelectPin;
    end
  end
  assign dualEdge = link.extendedControlEnable ? regDualEdge
                                               : link.dualEdgeEnable;

  // Clipping and offset binary; dual-edge feeds the chosen input to both.
  always_comb begin
    logic [7:0] selS;
    logic       selB;
    logic       selA;
    selS = (link.extendedControlEnable && regQSelect) ? qSample : iSample;
    selB = (link.extendedControlEnable && regQSelect) ? qBelow : iBelow;
    selA = (link.extendedControlEnable && regQSelect) ? qAbove : iAbove;
    iCode = iBelow ? CODE_ZERO : iAbove ? CODE_FULL : toOffsetBin(iSample);
    qCode = qBelow ? CODE_ZERO : qAbove ? CODE_FULL : toOffsetBin(qSample);
    clip  = iBelow | iAbove | qBelow | qAbove;
    if (dualEdge) begin
      iCode = selB ? CODE_ZERO : selA ? CODE_FULL : toOffsetBin(selS);
      qCode = iCode;
      clip  = selB | selA;
    end
  end

  // Latency pipeline; powered-down Q channel carries mid-scale outside dual-edge mode.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int k = 0; k < LAT_PRIMARY; k++) begin
        iPipe_q[k] <= CODE_MID;
        qPipe_q[k] <= CODE_MID;
      end
      orPipe_q <= '0;
    end else begin
      iPipe_q[0] <= iCode;
      qPipe_q[0] <= (link.secondChannelPowerDown && !dualEdge) ? CODE_MID
                                                               : qCode;
      orPipe_q   <= {orPipe_q[LAT_PRIMARY-2:0], clip};
      for (int k = 1; k < LAT_PRIMARY; k++) begin
        iPipe_q[k] <= iPipe_q[k-1];
        qPipe_q[k] <= qPipe_q[k-1];
      end
    end
  end

  // 1:2 demux: even sample held, odd sample releases both buses.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      phase_q                 <= 1'b0;
      iHold_q                 <= CODE_MID;
      qHold_q                 <= CODE_MID;
      link.iPrimaryBus        <= CODE_MID;
      link.iDelayedBus        <= CODE_MID;
      link.qPrimaryBus        <= CODE_MID;
      link.qDelayedBus        <= CODE_MID;
      link.outOfRange         <= 1'b0;
      link.forwardedDataClock <= 1'b0;
    end else if (powerDownActive) begin
      phase_q                 <= 1'b0;
      link.outOfRange         <= 1'b0;
      link.forwardedDataClock <= 1'b0;
    end else begin
      phase_q                 <= ~phase_q;
      link.forwardedDataClock <= phase_q;
      link.outOfRange         <= orPipe_q[LAT_PRIMARY-2] |
                                 orPipe_q[LAT_PRIMARY-1];
      if (!phase_q) begin
        iHold_q <= iPipe_q[LAT_PRIMARY-2];
        qHold_q <= qPipe_q[LAT_PRIMARY-2];
      end else begin
        link.iDelayedBus <= iHold_q;
        link.qDelayedBus <= qHold_q;
        link.iPrimaryBus <= iPipe_q[LAT_PRIMARY-2];
        link.qPrimaryBus <= qPipe_q[LAT_PRIMARY-2];
      end
    end
  end
endmodule : conv_device

// [rtl/conv_host.sv]
`timescale 1ns/100ps
module conv_host
  import conv_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic srst,
  // Link to the converter.
  conv_link_if.host link,
  // User requests and settings.
  input  wire logic calRequest,
  input  wire logic userRange,
  input  wire logic userPowerDown,
  input  wire logic userDualEdge,
  input  wire logic userExtended,
  input  wire logic userDelaySelect,
  // Status and re-interleaved samples.
  output logic       busy,
  output logic       calSeen,
  output logic       wordValid,
  output logic [7:0] word0,
  output logic [7:0] word1,
  output logic [7:0] word2,
  output logic [7:0] word3
);
  typedef enum logic [1:0] {IDLE, DRIVE_LOW, DRIVE_HIGH} hostState_t;
  hostState_t       state_q;
  logic [CMD_CNT_W-1:0] count_q;
  logic             pendCal_q;
  logic             rangeLast_q;
  logic [2:0]       dclkSync_q;
  logic [1:0]       calSync_q;

  // The mode is latched once at reset and never changed afterwards.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      link.extendedControlEnable <= userExtended;
      link.calDelaySelect        <= 1'b0;
      link.powerDownPin          <= 1'b0;
      link.secondChannelPowerDown <= 1'b0;
      link.outputLevelSelect     <= 1'b0;
      link.outputEdgeSelect      <= 1'b0;
      link.rangeSelectPin        <= 1'b0;
      link.dualEdgeEnable        <= 1'b0;
      rangeLast_q                <= 1'b0;
    end else begin
      link.calDelaySelect <= userDelaySelect;
      link.powerDownPin   <= userPowerDown;
      link.rangeSelectPin <= userRange;
      rangeLast_q         <= userRange;
      // Dual-edge only after a calibration has been seen.
      link.dualEdgeEnable <= userDualEdge && calSeen;
    end
  end

  // Host issues 644 low then 644 high; range change forces it.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q        <= IDLE;
      count_q        <= '0;
      pendCal_q      <= 1'b0;
      link.calReqPin <= 1'b1;
    end else begin
      unique case (state_q)
        IDLE: begin
          link.calReqPin <= 1'b1;
          if (pendCal_q) begin
            pendCal_q      <= 1'b0;
            state_q        <= DRIVE_LOW;
            count_q        <= '0;
            link.calReqPin <= 1'b0;
          end
        end
        DRIVE_LOW: begin
          count_q <= count_q + CMD_CNT_W'(1);
          if (count_q == CMD_CNT_W'(CMD_LOW_CYCLES + 3)) begin
            state_q        <= DRIVE_HIGH;
            count_q        <= '0;
            link.calReqPin <= 1'b1;
          end
        end
        DRIVE_HIGH: begin
          count_q <= count_q + CMD_CNT_W'(1);
          if (count_q == CMD_CNT_W'(CMD_HIGH_CYCLES + 3)) state_q <= IDLE;
        end
        default: state_q <= IDLE;
      endcase
      // A request in the cycle that takes the previous one is kept.
      if (calRequest || (userRange != rangeLast_q)) pendCal_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy       <= 1'b0;
      calSeen    <= 1'b0;
      calSync_q  <= '0;
      dclkSync_q <= '0;
    end else begin
      calSync_q  <= {calSync_q[0], link.calActiveFlag};
      dclkSync_q <= {dclkSync_q[1:0], link.forwardedDataClock};
      busy       <= (state_q != IDLE) || calSync_q[1];
      if (calSync_q[1]) calSeen <= 1'b1;
    end
  end

  // Capture on the data clock's rising edge, earliest word first.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wordValid <= 1'b0;
      word0     <= CODE_MID;
      word1     <= CODE_MID;
      word2     <= CODE_MID;
      word3     <= CODE_MID;
    end else begin
      wordValid <= dclkSync_q[1] && !dclkSync_q[2];
      if (dclkSync_q[1] && !dclkSync_q[2]) begin
        word0 <= link.dualEdgeEnable ? link.qDelayedBus : link.iDelayedBus;
        word1 <= link.dualEdgeEnable ? link.iDelayedBus : link.iPrimaryBus;
        word2 <= link.dualEdgeEnable ? link.qPrimaryBus : link.qDelayedBus;
        word3 <= link.dualEdgeEnable ? link.iPrimaryBus : link.qPrimaryBus;
      end
    end
  end
endmodule : conv_host

// [dv/conv_link_checker.sv]
`timescale 1ns/100ps
module conv_link_checker #(
  parameter int unsigned CAL_RUN = 16
) (
  // Clock and reset.
  input wire logic       core_clk,
  input wire logic       srst,
  // Link signals under watch.
  input wire logic       calReqPin,
  input wire logic       powerDownPin,
  input wire logic       calActiveFlag,
  input wire logic       forwardedDataClock,
  input wire logic [7:0] iPrimaryBus
);
  logic [10:0] lowCnt_q;
  logic [10:0] highCnt_q;
  logic        armed_q;
  logic [3:0]  sinceCmd_q;
  logic [31:0] calCnt_q;
  logic [3:0]  actCnt_q;
  logic [3:0]  pdCnt_q;
  logic        cmdHit;

  // The command is seen independently of the design's own detector.
  assign cmdHit = (highCnt_q == 11'h280);

  always_ff @(posedge core_clk) begin
    if (srst || calReqPin) lowCnt_q <= 11'h000;
    else if (lowCnt_q != 11'h280) lowCnt_q <= lowCnt_q + 11'h001;
  end

  always_ff @(posedge core_clk) begin
    if (srst) armed_q <= 1'b0;
    else if (!calReqPin) armed_q <= (lowCnt_q >= 11'h27F);
  end

  always_ff @(posedge core_clk) begin
    if (srst || !calReqPin || !armed_q) highCnt_q <= 11'h000;
    else if (highCnt_q != 11'h281) highCnt_q <= highCnt_q + 11'h001;
  end

  always_ff @(posedge core_clk) begin
    if (srst) sinceCmd_q <= 4'hF;
    else if (cmdHit) sinceCmd_q <= 4'h0;
    else if (sinceCmd_q != 4'hF) sinceCmd_q <= sinceCmd_q + 4'h1;
  end

  always_ff @(posedge core_clk) begin
    if (srst || !calActiveFlag) calCnt_q <= 32'h0;
    else calCnt_q <= calCnt_q + 32'h1;
  end

  always_ff @(posedge core_clk) begin
    if (srst || powerDownPin) actCnt_q <= 4'h0;
    else if (actCnt_q != 4'hF) actCnt_q <= actCnt_q + 4'h1;
  end

  always_ff @(posedge core_clk) begin
    if (srst || !powerDownPin || calActiveFlag) pdCnt_q <= 4'h0;
    else if (pdCnt_q != 4'hF) pdCnt_q <= pdCnt_q + 4'h1;
  end

  a_start_powered: assert property (@(posedge core_clk)
    disable iff (srst) $rose(calActiveFlag) |-> !$past(powerDownPin, 4))
    else $error("calibration started while powered down");
  a_cal_length: assert property (@(posedge core_clk)
    disable iff (srst) $fell(calActiveFlag) |-> calCnt_q == CAL_RUN)
    else $error("calibration flag high for wrong length");
  a_cmd_starts: assert property (@(posedge core_clk)
    disable iff (srst) (cmdHit && !calActiveFlag && actCnt_q == 4'hF)
    |-> ##[1:8] calActiveFlag)
    else $error("valid command did not start calibration");
  a_start_cause: assert property (@(posedge core_clk)
    disable iff (srst) $rose(calActiveFlag) |-> sinceCmd_q <= 4'h8)
    else $error("calibration started without a full command");
  a_clock_runs: assert property (@(posedge core_clk)
    disable iff (srst) actCnt_q >= 4'h8
    |-> forwardedDataClock != $past(forwardedDataClock))
    else $error("data clock not toggling while active");
  a_pd_defer: assert property (@(posedge core_clk)
    disable iff (srst) (calActiveFlag && $past(calActiveFlag))
    |-> forwardedDataClock != $past(forwardedDataClock))
    else $error("device powered down during calibration");
  a_pd_quiet: assert property (@(posedge core_clk)
    disable iff (srst) pdCnt_q >= 4'h8 |-> $stable(forwardedDataClock))
    else $error("data clock running while powered down");
  a_half_rate: assert property (@(posedge core_clk)
    disable iff (srst)
    (actCnt_q == 4'hF && !calActiveFlag && $changed(iPrimaryBus))
    |=> $stable(iPrimaryBus))
    else $error("bus updated faster than half rate");
endmodule : conv_link_checker

// [dv/dual_adc_cal_and_output_control_tb.sv]
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  totalChecks++; \
  if ((got) !== (exp)) begin \
    badCount++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module dual_adc_cal_and_output_control_tb;
  import conv_ctrl_pkg::*;
  localparam int unsigned CAL_RUN = 16;
  logic       core_clk = 1'b0;
  logic       srst     = 1'b1;
  logic [7:0] iSample, qSample, word0, word1, word2, word3;
  logic       iBelow, iAbove, qBelow, qAbove, seen;
  logic [4:0] regBits;
  logic       effOutputLevel, effOutputEdge, effRangeSelect, powerDownActive;
  logic       calRequest, userRange, userPowerDown, userDualEdge;
  logic       busy, calSeen, wordValid, extMode;
  int         badCount, totalChecks, n;
  int unsigned seedSink;

  always #20 core_clk = ~core_clk;

  conv_link_if link ();
  conv_device #(.CAL_RUN(CAL_RUN), .EXP_LOW(6), .EXP_HIGH(8)) conv_device_i (
    .core_clk(core_clk), .srst(srst), .link(link),
    .iSample(iSample), .iBelow(iBelow), .iAbove(iAbove),
    .qSample(qSample), .qBelow(qBelow), .qAbove(qAbove),
    .regOutputLevel(regBits[0]), .regOutputEdge(regBits[1]),
    .regRangeSelect(regBits[2]), .regDualEdge(regBits[3]),
    .regQSelect(regBits[4]), .effOutputLevel(effOutputLevel),
    .effOutputEdge(effOutputEdge), .effRangeSelect(effRangeSelect),
    .powerDownActive(powerDownActive));
  conv_host conv_host_i (
    .core_clk(core_clk), .srst(srst), .link(link),
    .calRequest(calRequest), .userRange(userRange),
    .userPowerDown(userPowerDown), .userDualEdge(userDualEdge),
    .userExtended(extMode), .userDelaySelect(1'b0), .busy(busy),
    .calSeen(calSeen), .wordValid(wordValid), .word0(word0),
    .word1(word1), .word2(word2), .word3(word3));
  conv_link_checker #(.CAL_RUN(CAL_RUN)) conv_link_checker_i (
    .core_clk(core_clk), .srst(srst), .calReqPin(link.calReqPin),
    .powerDownPin(link.powerDownPin), .calActiveFlag(link.calActiveFlag),
    .forwardedDataClock(link.forwardedDataClock),
    .iPrimaryBus(link.iPrimaryBus));

  // Adding half scale flips the sign bit, giving the offset code.
  function automatic logic [7:0] expCode(input logic [7:0] s,
                                         input logic [1:0] clip);
    if (clip[0]) return 8'h00;
    if (clip[1]) return 8'hFF;
    return s + 8'h80;
  endfunction : expCode

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc

  task automatic holdData(input logic [7:0] i, input logic [7:0] q,
                          input logic [1:0] ic, input logic [1:0] qc);
    iSample = i;
    qSample = q;
    {iAbove, iBelow} = ic;
    {qAbove, qBelow} = qc;
    regBits = 5'($urandom);
    cyc(20);
    `CHK(link.iPrimaryBus, expCode(i, ic))
    `CHK(link.iDelayedBus, expCode(i, ic))
    `CHK(link.qPrimaryBus, expCode(q, qc))
    `CHK(link.qDelayedBus, expCode(q, qc))
    `CHK(link.outOfRange, |{ic, qc})
    `CHK(effRangeSelect, userRange)
    `CHK(effOutputLevel, link.outputLevelSelect)
    `CHK(effOutputEdge, link.outputEdgeSelect)
  endtask : holdData

  task automatic calCmd();
    calRequest = 1'b1;
    cyc(1);
    calRequest = 1'b0;
    cyc(2);
    `CHK(busy, 1'b1)
  endtask : calCmd

  task automatic waitFlag(input int lim);
    seen = 1'b0;
    for (int w = 0; w < lim && !seen; w++) begin
      cyc(1);
      seen = (link.calActiveFlag === 1'b1);
    end
  endtask : waitFlag

  task automatic tallyAndFinish();
    $display("checks=%0d mismatches=%0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tallyAndFinish

  initial begin
    {iSample, qSample, iBelow, iAbove, qBelow, qAbove} = '0;
    {regBits, calRequest, userRange, userPowerDown, userDualEdge} = '0;
    extMode = 1'b0;
    seedSink = $urandom(32'h038D);
    cyc(6);
    `CHK(link.calActiveFlag, 1'b0)
    `CHK(link.iPrimaryBus, CODE_MID)
    `CHK(link.calReqPin, 1'b1)
    srst = 1'b0;
    holdData(8'h80, 8'h7F, 2'b00, 2'b00);
    holdData(8'h12, 8'h34, 2'b01, 2'b10);
    holdData(8'h55, 8'hAA, 2'b10, 2'b00);
    holdData(8'h00, 8'hFF, 2'b00, 2'b01);
    for (int r = 0; r < 8; r++) begin
      holdData(8'($urandom), 8'($urandom), 2'($urandom_range(2)),
               2'($urandom_range(2)));
    end
    holdData(8'h10, 8'h20, 2'b00, 2'b00);
    iSample = 8'h30;
    cyc(12);
    `CHK(link.iPrimaryBus, 8'h90)
    cyc(6);
    `CHK(link.iPrimaryBus, 8'hB0)
    `CHK(link.iDelayedBus, 8'hB0)
    for (int k = 0; k < 40; k++) begin
      iSample = k[0] ? 8'h11 : 8'h22;
      cyc(1);
    end
    `CHK(link.iPrimaryBus ^ link.iDelayedBus, 8'h33)
    calCmd();
    waitFlag(1500);
    `CHK(seen, 1'b1)
    n = 0;
    while (link.calActiveFlag === 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    `CHK(n, CAL_RUN)
    `CHK(calSeen, 1'b1)
    // Power-down raised mid-calibration must wait for the end of the run.
    calCmd();
    waitFlag(1500);
    userPowerDown = 1'b1;
    cyc(8);
    `CHK(powerDownActive, 1'b0)
    `CHK(link.calActiveFlag, 1'b1)
    cyc(20);
    `CHK(powerDownActive, 1'b1)
    calCmd();
    waitFlag(1500);
    `CHK(seen, 1'b0)
    userPowerDown = 1'b0;
    cyc(20);
    `CHK(powerDownActive, 1'b0)
    userRange = 1'b1;
    waitFlag(2000);
    `CHK(seen, 1'b1)
    cyc(40);
    `CHK(effRangeSelect, 1'b1)
    userDualEdge = 1'b1;
    regBits = 5'h1F;
    iSample = 8'h05;
    qSample = 8'h60;
    cyc(30);
    `CHK(link.qPrimaryBus, 8'h85)
    `CHK(link.qDelayedBus, 8'h85)
    for (int k = 0; k < 30; k++) begin
      iSample = 8'(k);
      cyc(1);
    end
    for (int w = 0; w < 8 && wordValid !== 1'b1; w++) cyc(1);
    `CHK(wordValid, 1'b1)
    `CHK(word0 <= word1 && word1 <= word2 && word2 <= word3, 1'b1)
    // A second reset brings the converter up in extended control mode.
    {userRange, userDualEdge} = 2'h0;
    extMode = 1'b1;
    qSample = 8'h60;
    srst = 1'b1;
    cyc(6);
    srst = 1'b0;
    regBits = 5'h1F;
    cyc(20);
    `CHK({effOutputLevel, effOutputEdge, effRangeSelect}, 3'h7)
    `CHK(link.iPrimaryBus, 8'hE0)
    `CHK(link.qPrimaryBus, 8'hE0)
    tallyAndFinish();
  end

  initial begin
    #2000000;
    badCount++;
    tallyAndFinish();
  end
endmodule : dual_adc_cal_and_output_control_tb
